// >>> verilog/temp_sensor_register_bank.sv
// Purpose: Pointer-addressed register bank with over-limit status for nine temperature channels.
// Assumes: A two-wire front end on link_clk delivers frame starts and bytes; conversions come on clk.
// Notes: Both resets are applied together so the crossing toggles start equal.
// Contract
// - An 8-bit pointer picks the register for every read and write.
// - First byte of every write frame loads the pointer.
// - Pointer resets to zero, selecting the local result.
// - Writes to unassigned pointers change nothing.
// - Reads of unassigned pointers are answered, with zero data.
// - Each result is 13 bits inside a 16-bit word.
// - Local result at pointer zero, remotes one to eight at pointers one to eight.
// - Low four result bits are sixteenths of a degree.
// - Results are read-only and overwritten on each completed conversion.
// - Results may be read at any time and show the last conversion.
// - Results read zero until the first conversion of that channel.
// - Writing one to bit 15 at 20h resets registers; reads give zero.
// - Software reset is ignored while locked.
// - Lock code locks, unlock code unlocks; reads 8000h locked, zero unlocked.
// - Status at 21h: bits 15-8 remotes eight to one, bit 7 local.
// - Flag sets when result exceeds the channel's limit register.
// - Flag clears itself at or below limit minus hysteresis at 38h.
// - Alert output low while any flag is set, high otherwise.
// - Limits hold bits 15-6, lower bits zero, reset 7FC0h.
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_register_bank #(
   parameter int NUM_CHANNELS = temp_sensor_pkg::NUM_CHANNELS
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic link_clk,
   input wire logic link_rst_b,
   input wire logic link_start,
   input wire logic link_read,
   input wire logic link_wr_valid,
   input wire logic [7:0] link_wr_data,
   input wire logic link_rd_req,
   output logic link_ready,
   output logic link_rd_valid,
   output logic [7:0] link_rd_data,
   input wire temp_sensor_pkg::conversion_type conversion,
   output logic overtemp_alert_out_b
);
   // ==========================================================================
   // Link-domain declarations
   logic req_toggle;
   temp_sensor_pkg::link_req_type req_word;
   logic ack_sync;
   logic ack_last;
   logic link_any;
   temp_sensor_pkg::link_req_type next_req_word;

   // ==========================================================================
   // System-domain declarations
   typedef enum logic [2:0] {
      XFER_IDLE,
      XFER_WR_POINTER,
      XFER_WR_HIGH,
      XFER_WR_LOW,
      XFER_RD_HIGH,
      XFER_RD_LOW
   } xfer_state_type;

   xfer_state_type xfer_state;
   logic req_sync;
   logic req_last;
   logic req_event;
   logic ack_toggle;
   logic [7:0] rsp_byte;
   logic [7:0] pointer;
   logic [7:0] write_high;
   logic [15:0] read_snapshot;
   logic [15:0] read_word;
   logic write_strobe;
   logic [15:0] write_word;
   logic soft_reset;
   logic locked;
   logic [15:0] hyst_word;
   logic [15:0] result_word [0:NUM_CHANNELS-1];
   logic [15:0] limit_word [0:NUM_CHANNELS-1];
   logic [NUM_CHANNELS-1:0] flags;
   logic [15:0] status_word;

   // ==========================================================================
   // Link side: one event in flight at a time
   // Ready drops while an event waits, so the front end must hold off
   assign link_ready = (req_toggle == ack_last);
   assign link_any = link_start || link_wr_valid || link_rd_req;

   // Start wins over a byte, a write byte over a read request
   always_comb begin
      next_req_word.data = link_wr_data;
      if (link_start) begin
         next_req_word.kind = link_read ? temp_sensor_pkg::LINK_START_READ : temp_sensor_pkg::LINK_START_WRITE;
      end else if (link_wr_valid) begin
         next_req_word.kind = temp_sensor_pkg::LINK_WRITE_BYTE;
      end else begin
         next_req_word.kind = temp_sensor_pkg::LINK_READ_BYTE;
      end
   end

   // Request word is held steady until the toggle is acknowledged
   always_ff @(posedge link_clk) begin
      if (!link_rst_b) begin
         req_toggle <= 1'b0;
         req_word <= '0;
      end else if (link_ready && link_any) begin
         req_toggle <= !req_toggle;
         req_word <= next_req_word;
      end
   end

   // Acknowledge returns from the system clock
   sync_bit u_ack_sync (
      .clk(link_clk),
      .rst_b(link_rst_b),
      .d(ack_toggle),
      .q(ack_sync)
   );

   // Read byte is stable in rsp_byte by the time the ack toggle arrives
   always_ff @(posedge link_clk) begin
      if (!link_rst_b) begin
         ack_last <= 1'b0;
         link_rd_valid <= 1'b0;
         link_rd_data <= 8'h00;
      end else begin
         link_rd_valid <= 1'b0;
         if (ack_sync != ack_last) begin
            ack_last <= ack_sync;
            if (req_word.kind == temp_sensor_pkg::LINK_READ_BYTE) begin
               link_rd_valid <= 1'b1;
               link_rd_data <= rsp_byte;
            end
         end
      end
   end

   // ==========================================================================
   // System side: detect a new event
   sync_bit u_req_sync (
      .clk(clk),
      .rst_b(rst_b),
      .d(req_toggle),
      .q(req_sync)
   );

   // New event on a toggle edge
   assign req_event = (req_sync != req_last);

   // Last toggle seen
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         req_last <= 1'b0;
      end else begin
         req_last <= req_sync;
      end
   end

   // ==========================================================================
   // Frame sequencer: pointer byte, then high/low pairs
   always_ff @(posedge clk) begin
      if (!rst_b || soft_reset) begin
         xfer_state <= XFER_IDLE;
      end else if (req_event) begin
         unique case (req_word.kind)
            temp_sensor_pkg::LINK_START_WRITE: xfer_state <= XFER_WR_POINTER;
            temp_sensor_pkg::LINK_START_READ: xfer_state <= XFER_RD_HIGH;
            temp_sensor_pkg::LINK_WRITE_BYTE: begin
               unique case (xfer_state)
                  XFER_WR_POINTER: xfer_state <= XFER_WR_HIGH;
                  XFER_WR_HIGH: xfer_state <= XFER_WR_LOW;
                  XFER_WR_LOW: xfer_state <= XFER_WR_HIGH;
                  XFER_IDLE, XFER_RD_HIGH, XFER_RD_LOW: xfer_state <= xfer_state;
               endcase
            end
            temp_sensor_pkg::LINK_READ_BYTE: begin
               xfer_state <= (xfer_state == XFER_RD_HIGH) ? XFER_RD_LOW : XFER_RD_HIGH;
            end
         endcase
      end
   end

   // Write commit on the low byte of each pair
   // Unused pointers hit nothing
   assign write_strobe = req_event && (req_word.kind == temp_sensor_pkg::LINK_WRITE_BYTE)
                         && (xfer_state == XFER_WR_LOW);
   assign write_word = {write_high, req_word.data};

   // High byte waits here until its partner arrives
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         write_high <= 8'h00;
      end else if (req_event && (req_word.kind == temp_sensor_pkg::LINK_WRITE_BYTE)
                   && (xfer_state == XFER_WR_HIGH)) begin
         write_high <= req_word.data;
      end
   end

   // ==========================================================================
   // Pointer
   // Set by every write frame
   always_ff @(posedge clk) begin
      if (!rst_b || soft_reset) begin
         pointer <= temp_sensor_pkg::POINTER_RESET;
      end else if (req_event && (req_word.kind == temp_sensor_pkg::LINK_WRITE_BYTE)
                   && (xfer_state == XFER_WR_POINTER)) begin
         pointer <= req_word.data;
      end
   end

   // ==========================================================================
   // Lock and software reset
   // Reset writes are dropped while locked, so a locked part cannot be wiped
   assign soft_reset = write_strobe && (pointer == temp_sensor_pkg::PTR_SOFT_RESET)
                       && write_word[temp_sensor_pkg::SOFT_RESET_BIT] && !locked;

   // Only the two exact codes move the lock; other values are ignored
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         locked <= temp_sensor_pkg::LOCK_RESET;
      end else if (write_strobe && (pointer == temp_sensor_pkg::PTR_LOCK)) begin
         if (write_word == temp_sensor_pkg::LOCK_CODE) begin
            locked <= 1'b1;
         end else if (write_word == temp_sensor_pkg::UNLOCK_CODE) begin
            locked <= 1'b0;
         end
      end
   end

   // Hysteresis shares the limit format and is lock protected
   always_ff @(posedge clk) begin
      if (!rst_b || soft_reset) begin
         hyst_word <= temp_sensor_pkg::HYST_RESET;
      end else if (write_strobe && (pointer == temp_sensor_pkg::PTR_HYST) && !locked) begin
         hyst_word <= write_word & temp_sensor_pkg::LIMIT_MASK;
      end
   end

   // ==========================================================================
   // Per-channel result, limit and comparator
   // Index is the channel code
   genvar ch;
   generate
      for (ch = 0; ch < NUM_CHANNELS; ch++) begin : g_channel
         // Result is overwritten by each conversion; host writes never reach it
         always_ff @(posedge clk) begin
            if (!rst_b || soft_reset) begin
               result_word[ch] <= temp_sensor_pkg::RESULT_RESET;
            end else if (conversion.valid && (conversion.channel == 4'(ch))) begin
               result_word[ch] <= {conversion.result, 3'b000};
            end
         end

         // Limit keeps only bits 15 down to 6
         always_ff @(posedge clk) begin
            if (!rst_b || soft_reset) begin
               limit_word[ch] <= temp_sensor_pkg::LIMIT_RESET;
            end else if (write_strobe && (pointer == temp_sensor_pkg::PTR_LIMIT[ch]) && !locked) begin
               limit_word[ch] <= write_word & temp_sensor_pkg::LIMIT_MASK;
            end
         end

         limit_compare u_compare (
            .clk(clk),
            .rst_b(rst_b),
            .clear(soft_reset),
            .result_word(result_word[ch]),
            .limit_word(limit_word[ch]),
            .hyst_word(hyst_word),
            .flag(flags[ch])
         );
      end
   endgenerate

   // ==========================================================================
   // Status word and alert pin
   // Bits 6:0 read zero
   assign status_word = {flags[NUM_CHANNELS-1:1], flags[0], 7'b000_0000};

   // Registered so the pin never glitches between compares
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         overtemp_alert_out_b <= 1'b1;
      end else begin
         overtemp_alert_out_b <= !(|flags);
      end
   end

   // ==========================================================================
   // Read mux on the current pointer
   // Unused pointers read zero
   always_comb begin
      read_word = temp_sensor_pkg::UNMAPPED_READ;
      if (pointer <= temp_sensor_pkg::PTR_REMOTE_LAST) begin
         read_word = result_word[pointer[3:0]];
      end else if (pointer == temp_sensor_pkg::PTR_SOFT_RESET) begin
         read_word = 16'h0000;
      end else if (pointer == temp_sensor_pkg::PTR_STATUS) begin
         read_word = status_word;
      end else if (pointer == temp_sensor_pkg::PTR_HYST) begin
         read_word = hyst_word;
      end else if (pointer == temp_sensor_pkg::PTR_LOCK) begin
         read_word = locked ? temp_sensor_pkg::LOCK_READ_LOCKED : temp_sensor_pkg::LOCK_READ_UNLOCKED;
      end
      for (int i = 0; i < NUM_CHANNELS; i++) begin
         if (pointer == temp_sensor_pkg::PTR_LIMIT[i]) begin
            read_word = limit_word[i];
         end
      end
   end

   // ==========================================================================
   // Answer byte and acknowledge
   // Word is captured at the high byte so both halves come from one conversion
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         read_snapshot <= 16'h0000;
         rsp_byte <= 8'h00;
      end else if (req_event && (req_word.kind == temp_sensor_pkg::LINK_READ_BYTE)) begin
         if (xfer_state == XFER_RD_LOW) begin
            rsp_byte <= read_snapshot[7:0];
         end else begin
            read_snapshot <= read_word;
            rsp_byte <= read_word[15:8];
         end
      end
   end

   // Every event is acknowledged, ignored ones included, so the link never hangs
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         ack_toggle <= 1'b0;
      end else if (req_event) begin
         ack_toggle <= !ack_toggle;
      end
   end
endmodule : temp_sensor_register_bank
`default_nettype wire

// >>> verilog/temp_sensor_pkg.sv
// Purpose: Shared constants and carrier types for the temperature sensor register bank.
// Assumes: Byte-level link events arrive from a two-wire front end on its own clock.
// Notes: Pointer values are the register addresses seen by the host.
`default_nettype none
package temp_sensor_pkg;
   // ==========================================================================
   // Widths
   localparam int PTR_W = 8;
   localparam int DATA_W = 16;
   localparam int RESULT_W = 13;
   localparam int RESULT_SHIFT = 3;
   localparam int NUM_CHANNELS = 9;
   // ==========================================================================
   // Pointer map
   localparam logic [7:0] PTR_LOCAL = 8'h00;
   localparam logic [7:0] PTR_REMOTE_LAST = 8'h08;
   localparam logic [7:0] PTR_SOFT_RESET = 8'h20;
   localparam logic [7:0] PTR_STATUS = 8'h21;
   localparam logic [7:0] PTR_HYST = 8'h38;
   localparam logic [7:0] PTR_LOCK = 8'hC4;
   localparam logic [7:0] PTR_LIMIT [0:8] = '{8'h39, 8'h42, 8'h4A, 8'h52, 8'h5A, 8'h62, 8'h6A, 8'h72, 8'h7A};
   // ==========================================================================
   // Field positions and values
   localparam int SOFT_RESET_BIT = 15;
   localparam int STATUS_LOCAL_BIT = 7;
   localparam int STATUS_REMOTE_LSB = 8;
   localparam logic [15:0] LIMIT_MASK = 16'hFFC0;
   localparam logic [15:0] LIMIT_RESET = 16'h7FC0;
   localparam logic [15:0] HYST_RESET = 16'h0000;
   localparam logic [15:0] RESULT_RESET = 16'h0000;
   localparam logic [15:0] LOCK_CODE = 16'h5CA6;
   localparam logic [15:0] UNLOCK_CODE = 16'hEB19;
   localparam logic [15:0] LOCK_READ_LOCKED = 16'h8000;
   localparam logic [15:0] LOCK_READ_UNLOCKED = 16'h0000;
   localparam logic LOCK_RESET = 1'b1;
   localparam logic [7:0] POINTER_RESET = 8'h00;
   localparam logic [15:0] UNMAPPED_READ = 16'h0000;
   // ==========================================================================
   // Carrier types
   typedef enum logic [1:0] {LINK_START_WRITE, LINK_START_READ, LINK_WRITE_BYTE, LINK_READ_BYTE} link_kind_type;
   typedef struct packed {
      link_kind_type kind;
      logic [7:0] data;
   } link_req_type;
   typedef struct packed {
      logic valid;
      logic [3:0] channel;
      logic [12:0] result;
   } conversion_type;
endpackage : temp_sensor_pkg
`default_nettype wire

// >>> verilog/sync_bit.sv
// Purpose: Two-flop synchroniser for one level or toggle.
// Assumes: Input changes no faster than the destination clock can follow.
// Notes: First flop feeds only the second.
`timescale 1ns/1ps
`default_nettype none
module sync_bit (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic d,
   output logic q
);
   logic meta;
   // ==========================================================================
   // Two stages, no logic between them
   always_ff @(posedge clk) begin
      if (!rst_b) begin
         meta <= 1'b0;
         q <= 1'b0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule : sync_bit
`default_nettype wire

// >>> verilog/limit_compare.sv
// Purpose: One channel's over-limit flag with hysteresis.
// Assumes: Result, limit and hysteresis share the 16-bit word format.
// Notes: Compared continuously against the stored result.
`timescale 1ns/1ps
`default_nettype none
module limit_compare (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic clear,
   input wire logic [15:0] result_word,
   input wire logic [15:0] limit_word,
   input wire logic [15:0] hyst_word,
   output logic flag
);
   logic signed [17:0] res_s;
   logic signed [17:0] lim_s;
   logic signed [17:0] thr_s;
   // Two extra bits so a low limit minus hysteresis cannot wrap
   assign res_s = {{2{result_word[15]}}, result_word};
   assign lim_s = {{2{limit_word[15]}}, limit_word};
   assign thr_s = lim_s - $signed({2'b00, hyst_word});
   // ==========================================================================
   // Set above the limit, clear at or below limit minus hysteresis
   always_ff @(posedge clk) begin
      if (!rst_b || clear) begin
         flag <= 1'b0;
      end else if (flag) begin
         flag <= !(res_s <= thr_s);
      end else begin
         flag <= res_s > lim_s;
      end
   end
endmodule : limit_compare
`default_nettype wire

// >>> verification/bank_checker_sva.sv
// Purpose: Port-level assertions for the temperature register bank.
// Assumes: Both resets are released together; link events follow the ready handshake.
// Notes: Link checks run on link_clk, alert checks on clk.
`timescale 1ns/1ps
`default_nettype none
module bank_checker #(
   parameter int NUM_CHANNELS = 9
) (
   input wire logic clk,
   input wire logic rst_b,
   input wire logic link_clk,
   input wire logic link_rst_b,
   input wire logic link_start,
   input wire logic link_read,
   input wire logic link_wr_valid,
   input wire logic [7:0] link_wr_data,
   input wire logic link_rd_req,
   input wire logic link_ready,
   input wire logic link_rd_valid,
   input wire logic [7:0] link_rd_data,
   input wire temp_sensor_pkg::conversion_type conversion,
   input wire logic overtemp_alert_out_b
);
   // =====================================
   // Link handshake
   take_drop_a: assert property (@(posedge link_clk) disable iff (!link_rst_b)
      link_ready && (link_start || link_wr_valid || link_rd_req) |=> !link_ready)
      else $error("link stayed ready after taking an event");
   ready_return_a: assert property (@(posedge link_clk) disable iff (!link_rst_b)
      !link_ready |-> ##[1:15] link_ready)
      else $error("link ready did not return");
   read_answer_a: assert property (@(posedge link_clk) disable iff (!link_rst_b)
      link_ready && link_rd_req && !link_start && !link_wr_valid |-> ##[2:12] link_rd_valid)
      else $error("read byte request got no answer");
   rd_pulse_a: assert property (@(posedge link_clk) disable iff (!link_rst_b)
      link_rd_valid |=> !link_rd_valid)
      else $error("read answer longer than one cycle");
   valid_ready_a: assert property (@(posedge link_clk) disable iff (!link_rst_b)
      link_rd_valid |-> link_ready)
      else $error("read answer without ready");
   data_hold_a: assert property (@(posedge link_clk) disable iff (!link_rst_b)
      !link_rd_valid |-> $stable(link_rd_data))
      else $error("read data moved outside an answer");
   write_silent_a: assert property (@(posedge link_clk) disable iff (!link_rst_b)
      link_ready && (link_start || link_wr_valid) |=> !link_rd_valid [*5])
      else $error("read answer after a write event");
   // =====================================
   // Alert; no limit can sit above the reset limit
   alert_hot_a: assert property (@(posedge clk) disable iff (!rst_b)
      conversion.valid && (conversion.channel < NUM_CHANNELS) &&
      ($signed({conversion.result, 3'b000}) > $signed(16'h7FC0)) |-> ##[2:4] !overtemp_alert_out_b)
      else $error("alert not driven low for a hot result");
endmodule : bank_checker
bind temp_sensor_register_bank bank_checker #(.NUM_CHANNELS(NUM_CHANNELS)) bank_checker_i (
   .clk(clk), .rst_b(rst_b), .link_clk(link_clk), .link_rst_b(link_rst_b), .link_start(link_start),
   .link_read(link_read), .link_wr_valid(link_wr_valid), .link_wr_data(link_wr_data),
   .link_rd_req(link_rd_req), .link_ready(link_ready), .link_rd_valid(link_rd_valid),
   .link_rd_data(link_rd_data), .conversion(conversion), .overtemp_alert_out_b(overtemp_alert_out_b));
`default_nettype wire

// >>> verification/link_host_model.sv
// Purpose: Two-wire host seen as byte events on the link side of the bank.
// Assumes: One event in flight; each waits for link_ready.
// Notes: gap adds idle link cycles before every event to play a slow host.
`timescale 1ns/1ps
`default_nettype none
module link_host_model (
   input wire logic link_clk,
   input wire logic link_ready,
   input wire logic link_rd_valid,
   input wire logic [7:0] link_rd_data,
   output logic link_start,
   output logic link_read,
   output logic link_wr_valid,
   output logic [7:0] link_wr_data,
   output logic link_rd_req
);
   int gap = 0;
   int lost = 0;
   // Idle levels at time zero
   initial begin
      link_start = 1'b0;
      link_read = 1'b0;
      link_wr_valid = 1'b0;
      link_wr_data = 8'h5A;
      link_rd_req = 1'b0;
   end
   // =====================================
   // One event: 0 start write, 1 start read, 2 write byte, 3 read byte
   task automatic send(input int kind, input logic [7:0] b, output logic [7:0] got);
      got = 8'h00;
      repeat (gap) @(posedge link_clk);
      for (int n = 0; n < 20; n++) begin
         @(posedge link_clk);
         if (link_ready === 1'b1) break;
      end
      lost += (link_ready !== 1'b1);
      link_start <= (kind < 2);
      link_read <= (kind == 1);
      link_wr_valid <= (kind == 2);
      link_rd_req <= (kind == 3);
      link_wr_data <= b;
      @(posedge link_clk);
      link_start <= 1'b0;
      link_wr_valid <= 1'b0;
      link_rd_req <= 1'b0;
      link_wr_data <= ~b; // Released byte shows no stale value
      if (kind == 3) begin
         for (int n = 0; n < 20; n++) begin
            @(posedge link_clk);
            if (link_rd_valid === 1'b1) break;
         end
         lost += (link_rd_valid !== 1'b1);
         got = link_rd_data;
      end
   endtask : send
   // Word write: pointer byte, then high and low byte
   task automatic write_word(input logic [7:0] ptr, input logic [15:0] d);
      logic [7:0] g;
      send(0, 8'h00, g);
      send(2, ptr, g);
      send(2, d[15:8], g);
      send(2, d[7:0], g);
   endtask : write_word
   // Word read, pointer written first unless skipped on purpose
   task automatic read_word(input logic [7:0] ptr, input logic set_ptr, output logic [15:0] d);
      logic [7:0] g;
      if (set_ptr) begin
         send(0, 8'h00, g);
         send(2, ptr, g);
      end
      send(1, 8'h00, g);
      send(3, 8'h00, d[15:8]);
      send(3, 8'h00, d[7:0]);
   endtask : read_word
endmodule : link_host_model
`default_nettype wire

// >>> verification/temp_sensor_register_bank_test.sv
// Purpose: Self-checking bench for the temperature register bank.
// Assumes: Host model drives the link; bench drives conversions.
// Notes: Limits, lock and soft reset are exercised through the link only.
`timescale 1ns/1ps
`default_nettype none
module temp_sensor_register_bank_test;
   typedef struct packed {logic [3:0] ch; logic [12:0] res; logic [7:0] ptr; logic [15:0] exp;} row_type;
   logic clk = 1'b0;
   logic link_clk = 1'b0;
   logic rst_b = 1'b0;
   logic link_rst_b = 1'b0;
   logic link_start, link_read, link_wr_valid, link_rd_req, link_ready, link_rd_valid;
   logic [7:0] link_wr_data, link_rd_data;
   logic overtemp_alert_out_b;
   logic [15:0] got;
   temp_sensor_pkg::conversion_type conversion = '0;
   int err_total = 0;
   int cmp_count = 0;
   row_type rows [0:9] = '{'{4'h0, 13'h00A1, 8'h00, 16'h0508}, '{4'h1, 13'h1FFF, 8'h01, 16'hFFF8},
      '{4'h2, 13'h0001, 8'h02, 16'h0008}, '{4'h3, 13'h0123, 8'h03, 16'h0918},
      '{4'h4, 13'h0FF0, 8'h04, 16'h7F80}, '{4'h5, 13'h1000, 8'h05, 16'h8000},
      '{4'h6, 13'h0555, 8'h06, 16'h2AA8}, '{4'h7, 13'h0AAA, 8'h07, 16'h5550},
      '{4'h8, 13'h0321, 8'h08, 16'h1908}, '{4'h9, 13'h1234, 8'h08, 16'h1908}};
   // Clocks, unrelated in phase
   always #5 clk = ~clk;
   always #16 link_clk = ~link_clk;
   temp_sensor_register_bank temp_sensor_register_bank_i (.clk(clk), .rst_b(rst_b), .link_clk(link_clk),
      .link_rst_b(link_rst_b), .link_start(link_start), .link_read(link_read), .link_wr_valid(link_wr_valid),
      .link_wr_data(link_wr_data), .link_rd_req(link_rd_req), .link_ready(link_ready),
      .link_rd_valid(link_rd_valid), .link_rd_data(link_rd_data), .conversion(conversion),
      .overtemp_alert_out_b(overtemp_alert_out_b));
   link_host_model link_host_model_i (.link_clk(link_clk), .link_ready(link_ready),
      .link_rd_valid(link_rd_valid), .link_rd_data(link_rd_data), .link_start(link_start),
      .link_read(link_read), .link_wr_valid(link_wr_valid), .link_wr_data(link_wr_data),
      .link_rd_req(link_rd_req));
   // =====================================
   // Compare and helper tasks
   task automatic check16(input logic [15:0] g, input logic [15:0] e);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %0t word %h expected %h", $time, g, e);
      end
   endtask : check16
   task automatic check1(input logic g, input logic e);
      cmp_count++;
      if (g !== e) begin
         err_total++;
         $display("ERROR %0t alert %b expected %b", $time, g, e);
      end
   endtask : check1
   task automatic rd(input logic [7:0] ptr, input logic [15:0] e);
      logic [15:0] g;
      link_host_model_i.read_word(ptr, 1'b1, g);
      check16(g, e);
   endtask : rd
   // Flag plus alert settle within a few clk after a result
   task automatic cv(input logic [3:0] ch, input logic [12:0] res);
      @(posedge clk);
      conversion <= '{valid: 1'b1, channel: ch, result: res};
      @(posedge clk);
      conversion.valid <= 1'b0;
      repeat (4) @(posedge clk);
   endtask : cv
   task automatic tally_and_finish;
      err_total += link_host_model_i.lost;
      if (err_total == 0 && cmp_count > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask : tally_and_finish
   // Watchdog, several times the expected run
   initial begin
      #300000;
      err_total++;
      tally_and_finish();
   end
   // =====================================
   // Main sequence; reset holds six clk cycles
   initial begin
      repeat (6) @(posedge clk);
      rst_b <= 1'b1;
      link_rst_b <= 1'b1;
      check1(overtemp_alert_out_b, 1'b1);
      cv(4'h0, 13'h00A1);
      link_host_model_i.read_word(8'h00, 1'b0, got);
      check16(got, 16'h0508);
      rd(8'h05, 16'h0000);
      for (int i = 0; i < 10; i++) begin
         cv(rows[i].ch, rows[i].res);
         rd(rows[i].ptr, rows[i].exp);
      end
      rd(8'h21, 16'h0000);
      rd(8'hC4, 16'h8000);
      rd(8'h39, 16'h7FC0);
      rd(8'h10, 16'h0000);
      // Result one step above the reset limit sets the flag, equal one clears
      cv(4'h2, 13'h0FF9);
      rd(8'h21, 16'h0200);
      check1(overtemp_alert_out_b, 1'b0);
      cv(4'h2, 13'h0FF8);
      rd(8'h21, 16'h0000);
      check1(overtemp_alert_out_b, 1'b1);
      // Ignored writes while locked
      link_host_model_i.write_word(8'h10, 16'hFFFF);
      link_host_model_i.write_word(8'h03, 16'h0000);
      link_host_model_i.write_word(8'h39, 16'h1234);
      link_host_model_i.write_word(8'h20, 16'h8000);
      rd(8'h03, 16'h0918);
      rd(8'h01, 16'hFFF8);
      rd(8'h39, 16'h7FC0);
      // Unlock, program limit and hysteresis with a slow host
      link_host_model_i.gap = 3;
      link_host_model_i.write_word(8'hC4, 16'hEB19);
      rd(8'hC4, 16'h0000);
      link_host_model_i.write_word(8'h52, 16'h0A3F);
      link_host_model_i.write_word(8'h38, 16'h0080);
      link_host_model_i.gap = 0;
      rd(8'h52, 16'h0A00);
      cv(4'h3, 13'h0141);
      rd(8'h21, 16'h0400);
      check1(overtemp_alert_out_b, 1'b0);
      cv(4'h3, 13'h0138);
      rd(8'h21, 16'h0400);
      cv(4'h3, 13'h0130);
      rd(8'h21, 16'h0000);
      check1(overtemp_alert_out_b, 1'b1);
      link_host_model_i.write_word(8'h39, 16'hFFC0);
      rd(8'h21, 16'h0080);
      // Soft reset: zero bit ignored, one bit clears
      link_host_model_i.write_word(8'h20, 16'h0000);
      rd(8'h21, 16'h0080);
      link_host_model_i.write_word(8'h20, 16'h8000);
      rd(8'h20, 16'h0000);
      rd(8'h00, 16'h0000);
      rd(8'h39, 16'h7FC0);
      rd(8'h21, 16'h0000);
      check1(overtemp_alert_out_b, 1'b1);
      link_host_model_i.write_word(8'hC4, 16'h5CA6);
      rd(8'hC4, 16'h8000);
      tally_and_finish();
   end
endmodule : temp_sensor_register_bank_test
`default_nettype wire
